// ### logic/fmda_core.v
// Functional notes
// - Registers move over either data bus as 24/48-bit, or 16/32-bit in 16-bit mode.
// - Operation sources come only from datapath registers, never straight from a bus.
// - In 16-bit mode source widths shrink to 16, 32 or 40 bits.
// - Every operation writes its result into one accumulator.
// - Two-stage pipeline takes a new operation every clock.
// - A result is usable by the next operation with no stall.
// - MAC takes up to three operands, gives one 56-bit extension:high:low result.
// - Fractional 24x24 multiply, signed, unsigned or mixed operands.
// - Right-justified 48-bit product adds to the full selected 56-bit accumulator.
// - A 56-bit accumulator can be stored as one 24-bit word.
// - Low part truncated by default, rounded into high part when requested.
// - Four 24-bit input registers feed multiplier and adder.
// - Two 56-bit accumulators, each extension, high and low parts.
// - Two limiters sit between accumulators and the buses on reads.
`default_nettype none
module fmda_core (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Mode
  input wire mode16_i,
  input wire lim_en_i,
  input wire limit_clr_i,
  // First memory data bus
  input wire first_bus_wr_en_i,
  input wire [3:0] first_bus_wr_sel_i,
  input wire [23:0] first_bus_wr_data_i,
  input wire first_bus_rd_en_i,
  input wire [3:0] first_bus_rd_sel_i,
  output reg [23:0] first_bus_rd_data_o,
  // Second memory data bus
  input wire second_bus_wr_en_i,
  input wire [3:0] second_bus_wr_sel_i,
  input wire [23:0] second_bus_wr_data_i,
  input wire second_bus_rd_en_i,
  input wire [3:0] second_bus_rd_sel_i,
  output reg [23:0] second_bus_rd_data_o,
  // Long moves over both buses
  input wire long_wr_en_i,
  input wire [1:0] long_wr_sel_i,
  input wire long_rd_en_i,
  input wire [1:0] long_rd_sel_i,
  // Operation issue
  input wire op_valid_i,
  input wire [2:0] op_code_i,
  input wire [1:0] op_src1_i,
  input wire [1:0] op_src2_i,
  input wire [1:0] op_sign_i,
  input wire op_round_i,
  input wire op_dst_i,
  input wire op_use_acc_i,
  input wire op_acc_src_i,
  // Status and state
  output reg rd_valid_o,
  output reg result_valid_o,
  output reg result_dst_o,
  output reg result_zero_o,
  output reg result_neg_o,
  output reg result_ext_o,
  output reg limit_flag_o,
  output reg [55:0] acc_a_o,
  output reg [55:0] acc_b_o
);
`include "fmda_defs.vh"

  // Input registers, indexed 0..3 as X0, X1, Y0, Y1
  reg [23:0] in_reg [0:3];
  reg [23:0] in_next [0:3];
  reg [55:0] acc_a_next;
  reg [55:0] acc_b_next;

  // Stage one state
  reg s1_valid_reg;
  reg [2:0] s1_code_reg;
  reg s1_dst_reg;
  reg s1_round_reg;
  reg s1_use_acc_reg;
  reg s1_acc_src_reg;
  reg s1_mode16_reg;
  reg [55:0] s1_opnd_reg;

  wire [47:0] prod;
  wire prod_signed;
  wire [23:0] fb_hi;
  wire [23:0] fb_lo;
  wire fb_lim;
  wire [23:0] sb_hi;
  wire [23:0] sb_lo;
  wire sb_lim;
  wire [55:0] fb_acc;
  wire [55:0] sb_acc;
  wire [23:0] mul_a;
  wire [23:0] mul_b;
  wire [1:0] fb_rd_lsel;

  reg [55:0] prod_ext;
  reg [55:0] base;
  reg [55:0] opnd;
  reg [55:0] sum;
  reg [55:0] res;
  reg [23:0] fb_word;
  reg [23:0] sb_word;
  reg lim_hit;

  integer i;
  integer j;

  // Operands are read from the input registers only
  assign mul_a = in_reg[op_src1_i];
  assign mul_b = in_reg[op_src2_i];

  fmda_mult u_mult (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .opa_i(mul_a),
    .opb_i(mul_b),
    .sign_i(op_sign_i),
    .prod_o(prod),
    .prod_signed_o(prod_signed)
  );

  // Long read routes the first limiter; otherwise each bus picks its own accumulator
  assign fb_rd_lsel = long_rd_en_i ? long_rd_sel_i : `FMDA_LSEL_A;
  assign fb_acc = (long_rd_en_i ? (fb_rd_lsel == `FMDA_LSEL_B) :
                  (first_bus_rd_sel_i == `FMDA_SEL_B)) ? acc_b_o : acc_a_o;
  assign sb_acc = (second_bus_rd_sel_i == `FMDA_SEL_B) ? acc_b_o : acc_a_o;

  fmda_limiter u_lim_first (
    .acc_i(fb_acc),
    .lim_en_i(lim_en_i),
    .mode16_i(mode16_i),
    .high_o(fb_hi),
    .low_o(fb_lo),
    .limited_o(fb_lim)
  );

  fmda_limiter u_lim_second (
    .acc_i(sb_acc),
    .lim_en_i(lim_en_i),
    .mode16_i(mode16_i),
    .high_o(sb_hi),
    .low_o(sb_lo),
    .limited_o(sb_lim)
  );

  // 16-bit mode keeps the upper 16 bits of each word
  function [23:0] narrow;
    input [23:0] d;
    input m16;
    begin
      narrow = m16 ? {d[23:8], 8'h00} : d;
    end
  endfunction

  function [23:0] pick;
    input [3:0] sel;
    input [23:0] lim_hi;
    input [23:0] x0;
    input [23:0] x1;
    input [23:0] y0;
    input [23:0] y1;
    input [55:0] a;
    input [55:0] b;
    begin
      case (sel)
        `FMDA_SEL_X0: pick = x0;
        `FMDA_SEL_X1: pick = x1;
        `FMDA_SEL_Y0: pick = y0;
        `FMDA_SEL_Y1: pick = y1;
        `FMDA_SEL_A0: pick = a[23:0];
        `FMDA_SEL_A1: pick = a[47:24];
        `FMDA_SEL_A2: pick = {{16{a[55]}}, a[55:48]};
        `FMDA_SEL_B0: pick = b[23:0];
        `FMDA_SEL_B1: pick = b[47:24];
        `FMDA_SEL_B2: pick = {{16{b[55]}}, b[55:48]};
        `FMDA_SEL_A: pick = lim_hi;
        `FMDA_SEL_B: pick = lim_hi;
        default: pick = `FMDA_RST_WORD;
      endcase
    end
  endfunction

  // Bus read words; a 24-bit accumulator store takes the limiter high word
  always @* begin
    fb_word = pick(first_bus_rd_sel_i, fb_hi, in_reg[0], in_reg[1], in_reg[2], in_reg[3],
                   acc_a_o, acc_b_o);
    sb_word = pick(second_bus_rd_sel_i, sb_hi, in_reg[0], in_reg[1], in_reg[2], in_reg[3],
                   acc_a_o, acc_b_o);
    lim_hit = 1'b0;
    if (long_rd_en_i) begin
      case (long_rd_sel_i)
        `FMDA_LSEL_X: begin
          fb_word = in_reg[1];
          sb_word = in_reg[0];
        end
        `FMDA_LSEL_Y: begin
          fb_word = in_reg[3];
          sb_word = in_reg[2];
        end
        default: begin
          fb_word = fb_hi;
          sb_word = fb_lo;
          lim_hit = fb_lim;
        end
      endcase
    end else begin
      if (first_bus_rd_en_i && first_bus_rd_sel_i >= `FMDA_SEL_A)
        lim_hit = fb_lim;
      if (second_bus_rd_en_i && second_bus_rd_sel_i >= `FMDA_SEL_A)
        lim_hit = lim_hit | sb_lim;
    end
  end

  // Stage two: accumulators are read here, so the previous result is already visible
  always @* begin
    prod_ext = {{8{prod_signed & prod[47]}}, prod};
    base = s1_dst_reg ? acc_b_o : acc_a_o;
    opnd = s1_use_acc_reg ? (s1_acc_src_reg ? acc_b_o : acc_a_o) : s1_opnd_reg;
    case (s1_code_reg)
      `FMDA_OP_MPY: sum = prod_ext;
      `FMDA_OP_MAC: sum = base + prod_ext;
      `FMDA_OP_MSUB: sum = base - prod_ext;
      `FMDA_OP_ADD: sum = base + opnd;
      `FMDA_OP_SUB: sum = base - opnd;
      `FMDA_OP_TFR: sum = opnd;
      `FMDA_OP_CLR: sum = `FMDA_RST_ACC;
      default: sum = base;
    endcase
    // Rounding is two's-complement, not convergent: simpler, slight upward bias
    if (s1_round_reg && s1_mode16_reg)
      res = (sum + `FMDA_RND_16) & `FMDA_RMASK_16;
    else if (s1_round_reg)
      res = (sum + `FMDA_RND_24) & `FMDA_RMASK_24;
    else
      res = sum;
    if (s1_mode16_reg)
      res = res & `FMDA_MASK_16;
  end

  // Register next values; operation result beats a bus write to the same accumulator
  always @* begin
    for (i = 0; i < 4; i = i + 1)
      in_next[i] = in_reg[i];
    acc_a_next = acc_a_o;
    acc_b_next = acc_b_o;
    if (second_bus_wr_en_i) begin
      case (second_bus_wr_sel_i)
        `FMDA_SEL_X0, `FMDA_SEL_X1, `FMDA_SEL_Y0, `FMDA_SEL_Y1:
          in_next[second_bus_wr_sel_i[1:0]] = narrow(second_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A0: acc_a_next[23:0] = narrow(second_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A1: acc_a_next[47:24] = narrow(second_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A2: acc_a_next[55:48] = second_bus_wr_data_i[7:0];
        `FMDA_SEL_B0: acc_b_next[23:0] = narrow(second_bus_wr_data_i, mode16_i);
        `FMDA_SEL_B1: acc_b_next[47:24] = narrow(second_bus_wr_data_i, mode16_i);
        `FMDA_SEL_B2: acc_b_next[55:48] = second_bus_wr_data_i[7:0];
        `FMDA_SEL_A: acc_a_next = {{8{second_bus_wr_data_i[23]}},
                                   narrow(second_bus_wr_data_i, mode16_i), 24'h000000};
        `FMDA_SEL_B: acc_b_next = {{8{second_bus_wr_data_i[23]}},
                                   narrow(second_bus_wr_data_i, mode16_i), 24'h000000};
        default: acc_a_next = acc_a_next;
      endcase
    end
    // First bus applied after the second bus so it wins a same-register collision
    if (first_bus_wr_en_i) begin
      case (first_bus_wr_sel_i)
        `FMDA_SEL_X0, `FMDA_SEL_X1, `FMDA_SEL_Y0, `FMDA_SEL_Y1:
          in_next[first_bus_wr_sel_i[1:0]] = narrow(first_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A0: acc_a_next[23:0] = narrow(first_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A1: acc_a_next[47:24] = narrow(first_bus_wr_data_i, mode16_i);
        `FMDA_SEL_A2: acc_a_next[55:48] = first_bus_wr_data_i[7:0];
        `FMDA_SEL_B0: acc_b_next[23:0] = narrow(first_bus_wr_data_i, mode16_i);
        `FMDA_SEL_B1: acc_b_next[47:24] = narrow(first_bus_wr_data_i, mode16_i);
        `FMDA_SEL_B2: acc_b_next[55:48] = first_bus_wr_data_i[7:0];
        `FMDA_SEL_A: acc_a_next = {{8{first_bus_wr_data_i[23]}},
                                   narrow(first_bus_wr_data_i, mode16_i), 24'h000000};
        `FMDA_SEL_B: acc_b_next = {{8{first_bus_wr_data_i[23]}},
                                   narrow(first_bus_wr_data_i, mode16_i), 24'h000000};
        default: acc_a_next = acc_a_next;
      endcase
    end
    if (long_wr_en_i) begin
      case (long_wr_sel_i)
        `FMDA_LSEL_X: begin
          in_next[1] = narrow(first_bus_wr_data_i, mode16_i);
          in_next[0] = narrow(second_bus_wr_data_i, mode16_i);
        end
        `FMDA_LSEL_Y: begin
          in_next[3] = narrow(first_bus_wr_data_i, mode16_i);
          in_next[2] = narrow(second_bus_wr_data_i, mode16_i);
        end
        `FMDA_LSEL_A: acc_a_next = {{8{first_bus_wr_data_i[23]}}, narrow(first_bus_wr_data_i, mode16_i),
                                    narrow(second_bus_wr_data_i, mode16_i)};
        default: acc_b_next = {{8{first_bus_wr_data_i[23]}}, narrow(first_bus_wr_data_i, mode16_i),
                               narrow(second_bus_wr_data_i, mode16_i)};
      endcase
    end
    if (s1_valid_reg && !s1_dst_reg)
      acc_a_next = res;
    if (s1_valid_reg && s1_dst_reg)
      acc_b_next = res;
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      for (j = 0; j < 4; j = j + 1)
        in_reg[j] <= `FMDA_RST_WORD;
      acc_a_o <= `FMDA_RST_ACC;
      acc_b_o <= `FMDA_RST_ACC;
      s1_valid_reg <= 1'b0;
      s1_code_reg <= `FMDA_OP_MPY;
      s1_dst_reg <= 1'b0;
      s1_round_reg <= 1'b0;
      s1_use_acc_reg <= 1'b0;
      s1_acc_src_reg <= 1'b0;
      s1_mode16_reg <= 1'b0;
      s1_opnd_reg <= `FMDA_RST_ACC;
      first_bus_rd_data_o <= `FMDA_RST_WORD;
      second_bus_rd_data_o <= `FMDA_RST_WORD;
      rd_valid_o <= 1'b0;
      result_valid_o <= 1'b0;
      result_dst_o <= 1'b0;
      result_zero_o <= 1'b0;
      result_neg_o <= 1'b0;
      result_ext_o <= 1'b0;
      limit_flag_o <= 1'b0;
    end else begin
      for (j = 0; j < 4; j = j + 1)
        in_reg[j] <= in_next[j];
      acc_a_o <= acc_a_next;
      acc_b_o <= acc_b_next;
      // Stage one captures a new operation every clock
      s1_valid_reg <= op_valid_i;
      s1_code_reg <= op_code_i;
      s1_dst_reg <= op_dst_i;
      s1_round_reg <= op_round_i;
      s1_use_acc_reg <= op_use_acc_i;
      s1_acc_src_reg <= op_acc_src_i;
      s1_mode16_reg <= mode16_i;
      s1_opnd_reg <= {{8{mul_a[23]}}, mul_a, 24'h000000};
      first_bus_rd_data_o <= narrow(fb_word, mode16_i);
      second_bus_rd_data_o <= narrow(sb_word, mode16_i);
      rd_valid_o <= first_bus_rd_en_i | second_bus_rd_en_i | long_rd_en_i;
      result_valid_o <= s1_valid_reg;
      result_dst_o <= s1_dst_reg;
      result_zero_o <= s1_valid_reg && (res == `FMDA_RST_ACC);
      result_neg_o <= s1_valid_reg && res[55];
      result_ext_o <= s1_valid_reg && (res[55:47] != {9{1'b0}}) && (res[55:47] != {9{1'b1}});
      // Set beats clear so a saturation in the clearing cycle is kept
      limit_flag_o <= lim_hit | (limit_flag_o & ~limit_clr_i);
    end
  end

endmodule
`default_nettype wire

// ### logic/fmda_defs.vh
`ifndef FMDA_DEFS_VH
`define FMDA_DEFS_VH

// Short register selects (one bus word)
`define FMDA_SEL_X0 4'h0
`define FMDA_SEL_X1 4'h1
`define FMDA_SEL_Y0 4'h2
`define FMDA_SEL_Y1 4'h3
`define FMDA_SEL_A0 4'h4
`define FMDA_SEL_A1 4'h5
`define FMDA_SEL_A2 4'h6
`define FMDA_SEL_B0 4'h7
`define FMDA_SEL_B1 4'h8
`define FMDA_SEL_B2 4'h9
`define FMDA_SEL_A 4'hA
`define FMDA_SEL_B 4'hB

// Long selects (high word on first bus, low word on second)
`define FMDA_LSEL_X 2'h0
`define FMDA_LSEL_Y 2'h1
`define FMDA_LSEL_A 2'h2
`define FMDA_LSEL_B 2'h3

// Operation codes
`define FMDA_OP_MPY 3'h0
`define FMDA_OP_MAC 3'h1
`define FMDA_OP_MSUB 3'h2
`define FMDA_OP_ADD 3'h3
`define FMDA_OP_SUB 3'h4
`define FMDA_OP_TFR 3'h5
`define FMDA_OP_CLR 3'h6

// Multiplier operand signedness
`define FMDA_SGN_SS 2'h0
`define FMDA_SGN_SU 2'h1
`define FMDA_SGN_UU 2'h2

// Rounding constants and masks
`define FMDA_RND_24 56'h00_000000_800000
`define FMDA_RND_16 56'h00_000080_000000
`define FMDA_RMASK_24 56'hFF_FFFFFF_000000
`define FMDA_RMASK_16 56'hFF_FFFF00_000000
`define FMDA_MASK_16 56'hFF_FFFF00_FFFF00

// Limiter saturation words
`define FMDA_SAT_POS 24'h7FFFFF
`define FMDA_SAT_NEG 24'h800000
`define FMDA_SAT_POS16 24'h7FFF00
`define FMDA_SAT_LOW 24'hFFFFFF
`define FMDA_SAT_LOW16 24'hFFFF00

// Reset value of every datapath register
`define FMDA_RST_WORD 24'h000000
`define FMDA_RST_ACC 56'h00_000000_000000

`endif

// ### logic/fmda_limiter.v
`default_nettype none
module fmda_limiter (
  // Accumulator in
  input wire [55:0] acc_i,
  input wire lim_en_i,
  input wire mode16_i,
  // Bus words out
  output reg [23:0] high_o,
  output reg [23:0] low_o,
  output reg limited_o
);
`include "fmda_defs.vh"

  reg over;

  // Value fits in 48 bits only if extension equals the sign of the high part
  always @* begin
    over = (acc_i[55:47] != {9{1'b0}}) && (acc_i[55:47] != {9{1'b1}});
    high_o = acc_i[47:24];
    low_o = acc_i[23:0];
    limited_o = 1'b0;
    if (lim_en_i && over) begin
      limited_o = 1'b1;
      if (acc_i[55]) begin
        high_o = `FMDA_SAT_NEG;
        low_o = `FMDA_RST_WORD;
      end else begin
        high_o = mode16_i ? `FMDA_SAT_POS16 : `FMDA_SAT_POS;
        low_o = mode16_i ? `FMDA_SAT_LOW16 : `FMDA_SAT_LOW;
      end
    end
  end

endmodule
`default_nettype wire

// ### logic/fmda_mult.v
`default_nettype none
module fmda_mult (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Operands
  input wire [23:0] opa_i,
  input wire [23:0] opb_i,
  input wire [1:0] sign_i,
  // Registered product
  output reg [47:0] prod_o,
  output reg prod_signed_o
);
`include "fmda_defs.vh"

  wire a_sgn;
  wire b_sgn;
  wire signed [24:0] a_ext;
  wire signed [24:0] b_ext;
  wire signed [49:0] full;

  // In mixed mode the first operand is the signed one
  assign a_sgn = (sign_i != `FMDA_SGN_UU);
  assign b_sgn = (sign_i == `FMDA_SGN_SS);
  assign a_ext = {a_sgn & opa_i[23], opa_i};
  assign b_ext = {b_sgn & opb_i[23], opb_i};
  assign full = a_ext * b_ext;

  // Fractional alignment drops the redundant sign bit
  always @(posedge clock_i) begin
    if (rst_i) begin
      prod_o <= 48'h000000000000;
      prod_signed_o <= 1'b0;
    end else begin
      prod_o <= {full[46:0], 1'b0};
      prod_signed_o <= a_sgn;
    end
  end

endmodule
`default_nettype wire

// ### testbench/fmda_bus_mem.sv
`default_nettype none
module fmda_bus_mem (
  // Clock
  input wire logic clock_i,
  // Words driven by the datapath
  input wire logic rd_valid_i,
  input wire logic [23:0] first_word_i,
  input wire logic [23:0] second_word_i,
  // Words last stored by memory
  output logic [23:0] first_seen_o,
  output logic [23:0] second_seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Memory stores only on the valid pulse, so a late or missing pulse leaves a stale word behind
  always @(posedge clock_i) begin
    if (rd_valid_i) begin
      first_seen_o <= first_word_i;
      second_seen_o <= second_word_i;
    end
  end
endmodule
`default_nettype wire

// ### testbench/fmda_core_assertions.sv
`default_nettype none
module fmda_core_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic mode16_i,
  input wire logic limit_clr_i,
  input wire logic first_bus_wr_en_i,
  input wire logic second_bus_wr_en_i,
  input wire logic long_wr_en_i,
  input wire logic first_bus_rd_en_i,
  input wire logic second_bus_rd_en_i,
  input wire logic long_rd_en_i,
  input wire logic op_valid_i,
  input wire logic op_dst_i,
  input wire logic rd_valid_o,
  input wire logic result_valid_o,
  input wire logic result_dst_o,
  input wire logic result_zero_o,
  input wire logic result_neg_o,
  input wire logic limit_flag_o,
  input wire logic [55:0] acc_a_o,
  input wire logic [23:0] first_bus_rd_data_o,
  input wire logic [23:0] second_bus_rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire any_rd = first_bus_rd_en_i | second_bus_rd_en_i | long_rd_en_i;
  wire any_wr = first_bus_wr_en_i | second_bus_wr_en_i | long_wr_en_i;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  rd_pulse_a: assert property (any_rd |=> rd_valid_o) else $error("read gave no valid");
  rd_quiet_a: assert property (!any_rd |=> !rd_valid_o) else $error("valid without read");
  op_latency_a: assert property (op_valid_i |-> ##2 result_valid_o) else $error("result late");
  result_cause_a: assert property (result_valid_o |-> $past(op_valid_i, 2)) else $error("stray result");
  result_dst_a: assert property (op_valid_i |-> ##2 result_dst_o == $past(op_dst_i, 2))
    else $error("wrong destination");
  acc_source_a: assert property ($changed(acc_a_o) |-> $past(any_wr) || (result_valid_o && !result_dst_o))
    else $error("accumulator changed alone");
  flag_match_a: assert property (result_valid_o && !result_dst_o |->
    result_zero_o == (acc_a_o == 56'h0) && result_neg_o == acc_a_o[55]) else $error("flags disagree");
  half_word_a: assert property (mode16_i |=> first_bus_rd_data_o[7:0] == 8'h00 &&
    second_bus_rd_data_o[7:0] == 8'h00) else $error("low byte in half mode");
  limit_hold_a: assert property (limit_flag_o && !limit_clr_i |=> limit_flag_o) else $error("flag lost");
  b2b_c: cover property (op_valid_i ##1 op_valid_i);
  limit_c: cover property ($rose(limit_flag_o));
  long_rd_c: cover property (long_rd_en_i ##1 rd_valid_o);
endmodule
bind fmda_core fmda_core_chk fmda_core_chk_i (.*);
`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none
`include "fmda_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = '0, rst_i = 1'b1, mode16_i = '0, lim_en_i = '0, limit_clr_i = '0, first_bus_wr_en_i = '0;
  logic first_bus_rd_en_i = '0, second_bus_wr_en_i = '0, second_bus_rd_en_i = '0, long_wr_en_i = '0;
  logic long_rd_en_i = '0, op_valid_i = '0, op_round_i = '0, op_dst_i = '0, op_use_acc_i = '0, op_acc_src_i = '0;
  logic [1:0] long_wr_sel_i = '0, long_rd_sel_i = '0, op_src1_i = '0, op_src2_i = '0, op_sign_i = '0;
  logic [2:0] op_code_i = '0;
  logic [3:0] first_bus_wr_sel_i = '0, first_bus_rd_sel_i = '0, second_bus_wr_sel_i = '0, second_bus_rd_sel_i = '0;
  logic [23:0] first_bus_wr_data_i = '0, second_bus_wr_data_i = '0, first_bus_rd_data_o, second_bus_rd_data_o;
  logic rd_valid_o, result_valid_o, result_dst_o, result_zero_o, result_neg_o, result_ext_o, limit_flag_o;
  logic [23:0] first_seen, second_seen;
  logic [23:0] regs [4];
  logic [55:0] acc_a_o, acc_b_o, exp_a;
  int mismatches, tests_run;

  fmda_core fmda_core_i (.*);
  fmda_bus_mem fmda_bus_mem_i (.clock_i(clock_i), .rd_valid_i(rd_valid_o), .first_word_i(first_bus_rd_data_o),
    .second_word_i(second_bus_rd_data_o), .first_seen_o(first_seen), .second_seen_o(second_seen));

  initial begin
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    repeat (3000) @(posedge clock_i);
    mismatches++;
    conclude();
  end

  task automatic conclude;
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [55:0] e, input logic [55:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // k: 0 first bus, 1 second bus, 2 long move over both
  task automatic wr(input int k, input logic [3:0] sel, input logic [23:0] d, input logic [23:0] lo = 24'h000000);
    @(posedge clock_i);
    first_bus_wr_en_i <= k == 0;
    second_bus_wr_en_i <= k == 1;
    long_wr_en_i <= k == 2;
    first_bus_wr_sel_i <= sel;
    second_bus_wr_sel_i <= sel;
    long_wr_sel_i <= sel[1:0];
    first_bus_wr_data_i <= d;
    second_bus_wr_data_i <= k == 2 ? lo : d;
    @(posedge clock_i);
    first_bus_wr_en_i <= 1'b0;
    second_bus_wr_en_i <= 1'b0;
    long_wr_en_i <= 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rdc(input int k, input logic [3:0] sel, input logic [23:0] e);
    @(posedge clock_i);
    first_bus_rd_en_i <= k == 0;
    second_bus_rd_en_i <= k == 1;
    long_rd_en_i <= k == 2;
    first_bus_rd_sel_i <= sel;
    second_bus_rd_sel_i <= sel;
    long_rd_sel_i <= sel[1:0];
    @(posedge clock_i);
    first_bus_rd_en_i <= 1'b0;
    second_bus_rd_en_i <= 1'b0;
    long_rd_en_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("bus word", e, k == 1 ? second_seen : first_seen);
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] a, b, sg, input logic r, d, ua);
    @(posedge clock_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_src1_i <= a;
    op_src2_i <= b;
    op_sign_i <= sg;
    op_round_i <= r;
    op_dst_i <= d;
    op_use_acc_i <= ua;
  endtask
  task automatic fin;
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("result valid", 56'h1, result_valid_o);
  endtask
  function automatic logic [55:0] fprod(input logic [23:0] a, b, input logic [1:0] s);
    logic signed [49:0] p;
    p = $signed({s != `FMDA_SGN_UU & a[23], a}) * $signed({s == `FMDA_SGN_SS & b[23], b});
    return {{8{s != `FMDA_SGN_UU & p[46]}}, p[46:0], 1'b0};
  endfunction
  function automatic logic [55:0] fop(input logic [2:0] c, input logic [55:0] acc, opnd, pr, input logic r);
    logic [55:0] v;
    case (c)
      `FMDA_OP_MPY: v = pr;
      `FMDA_OP_MAC: v = acc + pr;
      `FMDA_OP_MSUB: v = acc - pr;
      `FMDA_OP_ADD: v = acc + opnd;
      `FMDA_OP_SUB: v = acc - opnd;
      `FMDA_OP_TFR: v = opnd;
      default: v = 56'h0;
    endcase
    return r ? (v + `FMDA_RND_24) & `FMDA_RMASK_24 : v;
  endfunction

  task automatic t_bus;
    regs = '{24'h400000, 24'hC00000, 24'h200000, 24'h000005};
    wr(0, `FMDA_SEL_X0, regs[0]);
    wr(1, `FMDA_SEL_X1, regs[1]);
    wr(0, `FMDA_SEL_Y0, regs[2]);
    wr(1, `FMDA_SEL_Y1, regs[3]);
    rdc(0, `FMDA_SEL_X1, regs[1]);
    rdc(1, `FMDA_SEL_X0, regs[0]);
    rdc(1, `FMDA_SEL_Y1, regs[3]);
    rdc(0, 4'hF, 24'h000000);
  endtask
  task automatic t_long;
    wr(2, `FMDA_LSEL_A, 24'h123456, 24'hABCDEF);
    chk("acc a", 56'h00_123456_ABCDEF, acc_a_o);
    rdc(2, `FMDA_LSEL_A, 24'h123456);
    chk("low word", 56'hABCDEF, second_seen);
    rdc(0, `FMDA_SEL_A, 24'h123456);
    wr(1, `FMDA_SEL_A2, 24'h000001);
    exp_a = 56'h01_123456_ABCDEF;
    chk("acc a", exp_a, acc_a_o);
    @(posedge clock_i);
    lim_en_i <= 1'b1;
    rdc(1, `FMDA_SEL_A, `FMDA_SAT_POS);
    chk("limit flag", 56'h1, limit_flag_o);
    rdc(0, `FMDA_SEL_A2, 24'h000001);
    @(posedge clock_i);
    lim_en_i <= 1'b0;
    limit_clr_i <= 1'b1;
    @(posedge clock_i);
    limit_clr_i <= 1'b0;
    @(negedge clock_i);
    chk("limit flag", 56'h0, limit_flag_o);
  endtask
  // Every operation back to back into B, each ADD, SUB, MAC and MSUB consuming the previous result
  task automatic t_ops;
    logic [2:0] cd [8] = '{`FMDA_OP_CLR, `FMDA_OP_TFR, `FMDA_OP_ADD, `FMDA_OP_SUB, `FMDA_OP_MPY, `FMDA_OP_MAC,
      `FMDA_OP_MSUB, `FMDA_OP_ADD};
    logic [1:0] s1 [8] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3, 2'h0};
    logic [1:0] s2 [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    logic [1:0] sg [8] = '{2'h0, 2'h0, 2'h0, 2'h0, `FMDA_SGN_SS, `FMDA_SGN_SU, `FMDA_SGN_UU, 2'h0};
    logic [55:0] e, opnd;
    e = 56'h0;
    for (int i = 0; i < 8; i++) begin
      opnd = i == 7 ? exp_a : {{8{regs[s1[i]][23]}}, regs[s1[i]], 24'h000000};
      e = fop(cd[i], e, opnd, fprod(regs[s1[i]], regs[s2[i]], sg[i]), i == 6);
      op(cd[i], s1[i], s2[i], sg[i], i == 6, 1'b1, i == 7);
    end
    fin();
    chk("acc b", e, acc_b_o);
    chk("result dst", 56'h1, result_dst_o);
    chk("result ext", e[55:47] != 9'h000 && e[55:47] != 9'h1FF, result_ext_o);
    chk("result neg", e[55], result_neg_o);
  endtask
  task automatic t_round;
    op(`FMDA_OP_MPY, 2'h3, 2'h0, `FMDA_SGN_SS, 1'b0, 1'b0, 1'b0);
    fin();
    chk("acc a", 56'h00_000002_800000, acc_a_o);
    op(`FMDA_OP_MPY, 2'h3, 2'h0, `FMDA_SGN_SS, 1'b1, 1'b0, 1'b0);
    fin();
    chk("acc a", 56'h00_000003_000000, acc_a_o);
    op(`FMDA_OP_MPY, 2'h1, 2'h1, `FMDA_SGN_SS, 1'b0, 1'b0, 1'b0);
    fin();
    chk("acc a", 56'h00_200000_000000, acc_a_o);
    op(`FMDA_OP_CLR, 2'h0, 2'h0, `FMDA_SGN_SS, 1'b0, 1'b0, 1'b0);
    fin();
    chk("zero flag", 56'h1, result_zero_o);
    chk("acc a", 56'h0, acc_a_o);
    op(`FMDA_OP_MPY, 2'h0, 2'h1, `FMDA_SGN_SS, 1'b0, 1'b0, 1'b0);
    fin();
    chk("neg flag", 56'h1, result_neg_o);
    chk("acc a", 56'hFF_E00000_000000, acc_a_o);
  endtask
  // Negative saturation through the first limiter, positive through the second, then a raw long read of B
  task automatic t_sat;
    wr(0, `FMDA_SEL_A2, 24'h000080);
    @(posedge clock_i);
    lim_en_i <= 1'b1;
    rdc(0, `FMDA_SEL_A, `FMDA_SAT_NEG);
    chk("limit flag", 56'h1, limit_flag_o);
    rdc(1, `FMDA_SEL_B, `FMDA_SAT_POS);
    @(posedge clock_i);
    lim_en_i <= 1'b0;
    rdc(2, `FMDA_LSEL_B, 24'h023451);
    chk("low word", 56'hABCDEF, second_seen);
  endtask
  task automatic t_mode16;
    @(posedge clock_i);
    mode16_i <= 1'b1;
    wr(0, `FMDA_SEL_X0, 24'h1234AB);
    rdc(0, `FMDA_SEL_X0, 24'h123400);
    wr(1, `FMDA_SEL_Y1, 24'h01C000);
    op(`FMDA_OP_MPY, 2'h0, 2'h3, `FMDA_SGN_SS, 1'b1, 1'b0, 1'b0);
    fin();
    chk("acc a", 56'h00_004000_000000, acc_a_o);
    @(posedge clock_i);
    mode16_i <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    t_bus();
    t_long();
    t_ops();
    t_round();
    t_sat();
    t_mode16();
    conclude();
  end
endmodule
`default_nettype wire
